// *** suar_core.sv ***
// suar_core.sv: unit attention tracking and recovery sense selection
// assumes: a command front end presents one finished command per cycle
// at most, and drives event strobes from the same clock
`timescale 1ns/1ns
`include "suar_defs.svh"

module suar_core #(
  parameter int          NUM_INIT     = 16,
  parameter int          ID_W         = 32,
  parameter logic [15:0] PREDICT_THR  = `SUAR_PREDICT_THRESH
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // finished command from the front end
  input  wire logic                        cmd_valid,
  input  wire suar_pkg::suar_cmd_s         cmd,
  input  wire logic                        cmd_mismatch_miscmp,
  input  wire logic [ID_W-1:0]             cmd_new_id,
  // defect list request details
  input  wire logic                        dl_too_long,
  input  wire logic                        dl_fmt_block,
  input  wire logic                        dl_fmt_vendor,
  // bus events, pins from outside the clock domain
  input  wire logic                        bus_reset_pin,
  input  wire logic                        xcvr_mode_pin,
  // events from the same domain
  input  wire logic                        target_reset_msg,
  input  wire logic                        clear_queue_msg,
  input  wire logic [3:0]                  msg_initiator,
  input  wire logic [NUM_INIT-1:0]         queue_owner,
  input  wire logic                        format_ready,
  input  wire logic [3:0]                  format_initiator,
  input  wire logic                        ucode_valid,
  input  wire logic                        ucode_checked,
  input  wire logic                        ucode_ver_ok,
  input  wire logic                        powerup_check_done,
  input  wire logic                        state_unknown,
  input  wire logic                        error_log_event,
  // command end status and sense
  output logic                             rsp_valid,
  output suar_pkg::suar_status_e           rsp_status,
  output suar_pkg::suar_sense_s            rsp_sense,
  output logic                             rsp_phys_list,
  // effects on the rest of the drive
  output logic                             queue_discard,
  output logic                             abort_all,
  output logic                             release_reserve,
  output logic                             spindle_stop,
  output logic                             stats_clear,
  output logic [ID_W-1:0]                  device_id,
  output suar_pkg::suar_mode_e             drive_mode,
  output logic                             failure_prediction_alert
);

  localparam int IW = $clog2(NUM_INIT);

  if (NUM_INIT < 2 || NUM_INIT > 16 || ID_W < 1) begin : g_bad_param
    $error("NUM_INIT must be 2..16 and ID_W positive");
  end

  // ------
  // helpers
  // ------

  // all-ones mask of everyone except one initiator, whose bit is cleared
  function automatic logic [NUM_INIT-1:0] others(input logic [3:0] who);
    logic [NUM_INIT-1:0] m;
    m = '1;
    m[IW'(who)] = 1'b0;
    others = m;
  endfunction : others

  // good completion of a given opcode
  function automatic logic good_op(input suar_pkg::suar_cmd_s c, input logic v, input logic [7:0] op);
    good_op = v && c.ok && c.opcode == op;
  endfunction : good_op

  // ------
  // pin synchronisers
  // ------
  logic [1:0] busrst_sync_ff;
  logic [1:0] xcvr_sync_ff;
  logic       busrst_prev_ff;
  logic       xcvr_prev_ff;

  // two flops for each pin before any logic reads it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busrst_sync_ff <= 2'b00;
      xcvr_sync_ff   <= 2'b00;
      busrst_prev_ff <= 1'b0;
      xcvr_prev_ff   <= 1'b0;
    end else begin
      busrst_sync_ff <= {busrst_sync_ff[0], bus_reset_pin};
      xcvr_sync_ff   <= {xcvr_sync_ff[0], xcvr_mode_pin};
      busrst_prev_ff <= busrst_sync_ff[1];
      xcvr_prev_ff   <= xcvr_sync_ff[1];
    end
  end

  logic bus_reset_evt;
  logic xcvr_evt;
  assign bus_reset_evt = busrst_sync_ff[1] & ~busrst_prev_ff;
  assign xcvr_evt      = xcvr_sync_ff[1] ^ xcvr_prev_ff;

  // ------
  // drive mode
  // ------
  suar_pkg::suar_mode_e mode_ff;
  logic                 self_reset;
  logic                 mismatch_ff;

  assign self_reset = state_unknown && mode_ff != suar_pkg::SUAR_MODE_SELFRST;

  // bring-up, degraded on bad microcode, self reset when state is unknown
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff     <= suar_pkg::SUAR_MODE_BRINGUP;
      mismatch_ff <= 1'b0;
    end else begin
      case (mode_ff)
        suar_pkg::SUAR_MODE_BRINGUP: begin
          if (self_reset) begin
            mode_ff <= suar_pkg::SUAR_MODE_SELFRST;
          end else if (powerup_check_done) begin
            mismatch_ff <= ~ucode_ver_ok;
            mode_ff     <= suar_pkg::SUAR_MODE_READY;
          end
        end
        suar_pkg::SUAR_MODE_READY: begin
          if (self_reset) mode_ff <= suar_pkg::SUAR_MODE_SELFRST;
          else if (ucode_checked && !ucode_valid) mode_ff <= suar_pkg::SUAR_MODE_DEGRADED;
        end
        suar_pkg::SUAR_MODE_DEGRADED: begin
          if (self_reset) mode_ff <= suar_pkg::SUAR_MODE_SELFRST;
          else if (ucode_checked && ucode_valid) mode_ff <= suar_pkg::SUAR_MODE_READY;
        end
        suar_pkg::SUAR_MODE_SELFRST: begin
          if (!state_unknown) mode_ff <= suar_pkg::SUAR_MODE_BRINGUP;
        end
        default: mode_ff <= suar_pkg::SUAR_MODE_BRINGUP;
      endcase
    end
  end

  // ------
  // unit attention posting
  // ------
  logic [`SUAR_UA_NUM-1:0][NUM_INIT-1:0] post_mask;
  logic                                   any_reset;

  assign any_reset = bus_reset_evt | xcvr_evt | target_reset_msg | self_reset;

  // each cause posts to its own set of initiators, issuer excluded; reset and microcode causes post to all initiators
  always_comb begin
    post_mask = '0;
    if (any_reset) post_mask[`SUAR_UA_RESET] = '1;
    if (format_ready) post_mask[`SUAR_UA_READY] = others(format_initiator);
    if (clear_queue_msg) post_mask[`SUAR_UA_CLEARED] = queue_owner & others(msg_initiator);
    if (good_op(cmd, cmd_valid, `SUAR_OP_MODE_SELECT))
      post_mask[`SUAR_UA_MODE] = others(cmd.initiator);
    if (good_op(cmd, cmd_valid, `SUAR_OP_WRITE_BUFFER) && ucode_valid)
      post_mask[`SUAR_UA_UCODE] = '1;
    if (good_op(cmd, cmd_valid, `SUAR_OP_LOG_SELECT))
      post_mask[`SUAR_UA_LOG] = others(cmd.initiator);
    if (good_op(cmd, cmd_valid, `SUAR_OP_SET_DEV_ID))
      post_mask[`SUAR_UA_DEVID] = others(cmd.initiator);
  end

  logic [NUM_INIT-1:0]                    pend_any;
  logic [NUM_INIT-1:0][`SUAR_UA_NUM-1:0] pend_vec;
  logic                                   report_stb;

  suar_pend #(
    .NUM_INIT (NUM_INIT)
  ) u_pend (
    .mclk        (mclk),
    .sys_rst     (sys_rst),
    .post_mask   (post_mask),
    .report_stb  (report_stb),
    .report_init (IW'(cmd.initiator)),
    .pend_any    (pend_any),
    .pend_vec    (pend_vec)
  );

  // ------
  // failure prediction
  // ------
  logic [15:0] errlog_cnt_ff;
  logic        alert_ff;

  // count logged errors; threshold raises the alert until next reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      errlog_cnt_ff <= 16'h0000;
      alert_ff      <= 1'b0;
    end else begin
      if (error_log_event && errlog_cnt_ff != 16'hFFFF) errlog_cnt_ff <= errlog_cnt_ff + 16'h0001;
      if (errlog_cnt_ff >= PREDICT_THR) alert_ff <= 1'b1;
    end
  end

  // ------
  // sense selection for the finishing command
  // ------

  // sense of the highest pending attention cause
  function automatic suar_pkg::suar_sense_s ua_sense(input logic [`SUAR_UA_NUM-1:0] v);
    suar_pkg::suar_sense_s s;
    s.key  = `SUAR_KEY_UNIT_ATTN;
    s.asc  = `SUAR_ASC_UA_RESET;
    s.ascq = `SUAR_ASQ_ZERO;
    if (v[`SUAR_UA_RESET]) begin
      s.asc = `SUAR_ASC_UA_RESET;
    end else if (v[`SUAR_UA_READY]) begin
      s.asc = `SUAR_ASC_UA_READY;
    end else if (v[`SUAR_UA_CLEARED]) begin
      s.asc = `SUAR_ASC_UA_CLEARED;
    end else if (v[`SUAR_UA_MODE]) begin
      s.asc  = `SUAR_ASC_UA_PARAM;
      s.ascq = `SUAR_ASQ_UA_MODE;
    end else if (v[`SUAR_UA_UCODE]) begin
      s.asc  = `SUAR_ASC_UA_UCODE;
      s.ascq = `SUAR_ASQ_UA_UCODE;
    end else if (v[`SUAR_UA_LOG]) begin
      s.asc  = `SUAR_ASC_UA_PARAM;
      s.ascq = `SUAR_ASQ_UA_LOG;
    end else begin
      s.asc  = `SUAR_ASC_UA_UCODE;
      s.ascq = `SUAR_ASQ_UA_DEVID;
    end
    ua_sense = s;
  endfunction : ua_sense

  suar_pkg::suar_sense_s nxt_sense;
  suar_pkg::suar_status_e nxt_status;
  logic                  nxt_phys;
  logic                  is_verify;

  assign is_verify = cmd.opcode == `SUAR_OP_VERIFY ||
                     (cmd.opcode == `SUAR_OP_WRITE_VERIFY && cmd.byte_compare_flag);
  assign report_stb = cmd_valid && pend_any[IW'(cmd.initiator)];

  // attention first, then hard faults, then recovered notices
  always_comb begin
    nxt_status = suar_pkg::SUAR_ST_GOOD;
    nxt_sense  = '{key: `SUAR_KEY_NO_SENSE, asc: 8'h00, ascq: 8'h00};
    nxt_phys   = 1'b0;
    if (pend_any[IW'(cmd.initiator)]) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = ua_sense(pend_vec[IW'(cmd.initiator)]);
    end else if (mismatch_ff) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = '{key: `SUAR_KEY_HW_ERROR, asc: `SUAR_ASC_MISMATCH, ascq: `SUAR_ASQ_MISMATCH};
    end else if (mode_ff == suar_pkg::SUAR_MODE_DEGRADED) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = '{key: `SUAR_KEY_NOT_READY, asc: `SUAR_ASC_MICROCODE, ascq: `SUAR_ASQ_MICROCODE};
    end else if (is_verify && cmd_mismatch_miscmp) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = '{key: `SUAR_KEY_MISCOMPARE, asc: `SUAR_ASC_MISCMP, ascq: `SUAR_ASQ_ZERO};
    end else if (dl_too_long) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = '{key: `SUAR_KEY_RECOVERED, asc: `SUAR_ASC_LIST_LONG, ascq: `SUAR_ASQ_LIST_LONG};
    end else if (dl_fmt_block || dl_fmt_vendor) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_phys   = 1'b1;
      nxt_sense  = '{key: `SUAR_KEY_RECOVERED, asc: `SUAR_ASC_LIST_FMT,
                     ascq: dl_fmt_block ? `SUAR_ASQ_LIST_BLK : `SUAR_ASQ_LIST_VND};
    end else if (alert_ff) begin
      nxt_status = suar_pkg::SUAR_ST_CHECK;
      nxt_sense  = '{key: `SUAR_KEY_NO_SENSE, asc: `SUAR_ASC_PREDICT, ascq: `SUAR_ASQ_PREDICT};
    end
  end

  // registered command answer; the changing command itself ends good
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid     <= 1'b0;
      rsp_status    <= suar_pkg::SUAR_ST_GOOD;
      rsp_sense     <= '0;
      rsp_phys_list <= 1'b0;
    end else begin
      rsp_valid     <= cmd_valid;
      rsp_status    <= nxt_status;
      rsp_sense     <= nxt_sense;
      rsp_phys_list <= nxt_phys;
    end
  end

  // ------
  // side effects on the drive
  // ------
  logic [ID_W-1:0] id_ff;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      queue_discard   <= 1'b0;
      abort_all       <= 1'b0;
      release_reserve <= 1'b0;
      spindle_stop    <= 1'b0;
      stats_clear     <= 1'b0;
      id_ff           <= '0;
    end else begin
      queue_discard   <= clear_queue_msg;
      abort_all       <= self_reset;
      release_reserve <= self_reset;
      spindle_stop    <= self_reset;
      stats_clear     <= good_op(cmd, cmd_valid, `SUAR_OP_LOG_SELECT);
      if (good_op(cmd, cmd_valid, `SUAR_OP_SET_DEV_ID)) id_ff <= cmd_new_id;
    end
  end

  // registered status outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      drive_mode               <= suar_pkg::SUAR_MODE_BRINGUP;
      failure_prediction_alert <= 1'b0;
    end else begin
      drive_mode               <= mode_ff;
      failure_prediction_alert <= alert_ff;
    end
  end

  assign device_id = id_ff;

endmodule : suar_core

// *** suar_defs.svh ***
// suar_defs.svh: constants for the unit attention recovery block
// assumes: included by bare name from the package and the design modules
`ifndef SUAR_DEFS_SVH
`define SUAR_DEFS_SVH

// command opcodes
`define SUAR_OP_FORMAT        8'h04
`define SUAR_OP_MODE_SELECT   8'h15
`define SUAR_OP_WRITE_BUFFER  8'h3B
`define SUAR_OP_LOG_SELECT    8'h4C
`define SUAR_OP_SET_DEV_ID    8'hA4
`define SUAR_OP_VERIFY        8'h2F
`define SUAR_OP_WRITE_VERIFY  8'h2E

// sense keys
`define SUAR_KEY_NO_SENSE     4'h0
`define SUAR_KEY_RECOVERED    4'h1
`define SUAR_KEY_NOT_READY    4'h2
`define SUAR_KEY_MISCOMPARE   4'hE
`define SUAR_KEY_HW_ERROR     4'h4
`define SUAR_KEY_UNIT_ATTN    4'h6

// additional sense code / qualifier pairs
`define SUAR_ASC_MISMATCH     8'h40
`define SUAR_ASQ_MISMATCH     8'h80
`define SUAR_ASC_LIST_LONG    8'h1F
`define SUAR_ASQ_LIST_LONG    8'h00
`define SUAR_ASC_LIST_FMT     8'h1C
`define SUAR_ASQ_LIST_BLK     8'h01
`define SUAR_ASQ_LIST_VND     8'h02
`define SUAR_ASC_PREDICT      8'h5D
`define SUAR_ASQ_PREDICT      8'h00
`define SUAR_ASC_UA_READY     8'h28
`define SUAR_ASC_UA_RESET     8'h29
`define SUAR_ASC_UA_PARAM     8'h2A
`define SUAR_ASC_UA_UCODE     8'h3F
`define SUAR_ASC_UA_CLEARED   8'h2F
`define SUAR_ASC_MICROCODE    8'h40
`define SUAR_ASQ_MICROCODE    8'h81
`define SUAR_ASC_MISCMP       8'h1D
`define SUAR_ASQ_ZERO         8'h00
`define SUAR_ASQ_UA_LOG       8'h02
`define SUAR_ASQ_UA_DEVID     8'h05
`define SUAR_ASQ_UA_MODE      8'h01
`define SUAR_ASQ_UA_UCODE     8'h01

// unit attention cause positions, lower index reported first
`define SUAR_UA_RESET         0
`define SUAR_UA_READY         1
`define SUAR_UA_CLEARED       2
`define SUAR_UA_MODE          3
`define SUAR_UA_UCODE         4
`define SUAR_UA_LOG           5
`define SUAR_UA_DEVID         6
`define SUAR_UA_NUM           7

// default error log threshold for the failure prediction
`define SUAR_PREDICT_THRESH   16'h0010

`endif

// *** suar_pkg.sv ***
// suar_pkg.sv: types shared by the unit attention recovery block
// assumes: suar_defs.svh is on the include path
`include "suar_defs.svh"

package suar_pkg;

  // one command as presented by the command front end
  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] initiator;
    logic       byte_compare_flag;
    logic       ok;
  } suar_cmd_s;

  // sense triple returned with a check condition
  typedef struct packed {
    logic [3:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
  } suar_sense_s;

  // end status of a command
  typedef enum logic [1:0] {
    SUAR_ST_GOOD  = 2'b00,
    SUAR_ST_CHECK = 2'b01
  } suar_status_e;

  // bring-up and operating state, gray along power-up path
  typedef enum logic [1:0] {
    SUAR_MODE_BRINGUP  = 2'b00,
    SUAR_MODE_READY    = 2'b01,
    SUAR_MODE_DEGRADED = 2'b11,
    SUAR_MODE_SELFRST  = 2'b10
  } suar_mode_e;

endpackage : suar_pkg

// *** suar_pend.sv ***
// suar_pend.sv: per-initiator pending unit attention flags
// assumes: one clock; set and report strobes come from the same domain
`timescale 1ns/1ns
`include "suar_defs.svh"

module suar_pend #(
  parameter int NUM_INIT = 16
) (
  // clock and reset
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  // cause posting, one mask of initiators per cause
  input  wire logic [`SUAR_UA_NUM-1:0][NUM_INIT-1:0] post_mask,
  // report of the highest cause to one initiator
  input  wire logic                              report_stb,
  input  wire logic [$clog2(NUM_INIT)-1:0]       report_init,
  // pending view
  output logic      [NUM_INIT-1:0]               pend_any,
  output logic      [NUM_INIT-1:0][`SUAR_UA_NUM-1:0] pend_vec
);

  logic [NUM_INIT-1:0][`SUAR_UA_NUM-1:0] flag_ff;

  // lowest set bit of a cause vector
  function automatic logic [`SUAR_UA_NUM-1:0] first_one(input logic [`SUAR_UA_NUM-1:0] v);
    first_one = v & (~v + `SUAR_UA_NUM'(1));
  endfunction : first_one

  // one flag set per initiator and cause; set wins over the clear
  genvar gi, gc;
  generate
    for (gi = 0; gi < NUM_INIT; gi++) begin : g_init
      logic [`SUAR_UA_NUM-1:0] clr;
      logic [`SUAR_UA_NUM-1:0] set;
      always_comb begin
        clr = (report_stb && report_init == gi) ? first_one(flag_ff[gi]) : '0;
      end
      for (gc = 0; gc < `SUAR_UA_NUM; gc++) begin : g_cause
        assign set[gc] = post_mask[gc][gi];
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          flag_ff[gi] <= `SUAR_UA_NUM'(1); // power-on reset attention
        end else begin
          flag_ff[gi] <= (flag_ff[gi] & ~clr) | set;
        end
      end
      assign pend_any[gi] = |flag_ff[gi];
      assign pend_vec[gi] = flag_ff[gi];
    end
  endgenerate

endmodule : suar_pend

// *** suar_core_asserts.sv ***
// suar_core_asserts.sv: port-level checks for the unit attention core
// assumes: bound to suar_core, one clock, async active-high reset
`timescale 1ns/1ns
module suar_core_asserts #(
  parameter int ID_W = 32
) (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   sys_rst,
  // watched inputs
  input wire logic                   cmd_valid,
  input wire suar_pkg::suar_cmd_s    cmd,
  input wire logic [ID_W-1:0]        cmd_new_id,
  input wire logic                   clear_queue_msg,
  input wire logic                   ucode_checked,
  input wire logic                   ucode_valid,
  input wire logic                   state_unknown,
  // watched outputs
  input wire logic                   rsp_valid,
  input wire suar_pkg::suar_status_e rsp_status,
  input wire suar_pkg::suar_sense_s  rsp_sense,
  input wire logic                   queue_discard,
  input wire logic                   abort_all,
  input wire logic                   release_reserve,
  input wire logic                   spindle_stop,
  input wire logic                   stats_clear,
  input wire logic [ID_W-1:0]        device_id,
  input wire suar_pkg::suar_mode_e   drive_mode,
  input wire logic                   failure_prediction_alert
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ------
  // command answer timing
  // ------
  sequence s_taken; cmd_valid; endsequence
  sequence s_answer; rsp_valid; endsequence
  property p_latency; s_taken |=> s_answer; endproperty
  a_latency: assert property (p_latency) else $error("command without answer");
  property p_no_spurious; !cmd_valid |=> !rsp_valid; endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without command");
  // ------
  // sense and side effects
  // ------
  property p_ua_codes;
    rsp_valid && rsp_status == suar_pkg::SUAR_ST_CHECK && rsp_sense.key == 4'h6
      |-> rsp_sense.asc inside {8'h28, 8'h29, 8'h2a, 8'h3f, 8'h2f};
  endproperty
  a_ua_codes: assert property (p_ua_codes) else $error("notice key with bad code");
  property p_miscmp;
    cmd_valid && !(cmd.opcode == 8'h2f || (cmd.opcode == 8'h2e && cmd.byte_compare_flag))
      |=> rsp_sense.key != 4'he;
  endproperty
  a_miscmp: assert property (p_miscmp) else $error("miscompare on wrong command");
  property p_selfrst;
    state_unknown && !abort_all && drive_mode != suar_pkg::SUAR_MODE_SELFRST
      |=> abort_all && release_reserve && spindle_stop;
  endproperty
  a_selfrst: assert property (p_selfrst) else $error("self reset effects missing");
  property p_one_shot; abort_all |=> !abort_all; endproperty
  a_one_shot: assert property (p_one_shot) else $error("abort longer than a pulse");
  property p_stats; cmd_valid && cmd.opcode == 8'h4c && cmd.ok |=> stats_clear; endproperty
  a_stats: assert property (p_stats) else $error("statistics not cleared");
  property p_devid; cmd_valid && cmd.opcode == 8'ha4 && cmd.ok |=> device_id == $past(cmd_new_id); endproperty
  a_devid: assert property (p_devid) else $error("identifier not updated");
  property p_qdisc; clear_queue_msg |=> queue_discard; endproperty
  a_qdisc: assert property (p_qdisc) else $error("queue not discarded");
  property p_degrade;
    drive_mode == suar_pkg::SUAR_MODE_READY && !abort_all && ucode_checked && !ucode_valid && !state_unknown
      |=> ##1 drive_mode == suar_pkg::SUAR_MODE_DEGRADED;
  endproperty
  a_degrade: assert property (p_degrade) else $error("bad microcode did not degrade");
  property p_alert; failure_prediction_alert |=> failure_prediction_alert; endproperty
  a_alert: assert property (p_alert) else $error("alert dropped");
endmodule : suar_core_asserts

// *** suar_init_model.sv ***
// suar_init_model.sv: behavioural initiators on the command side
// assumes: one command in flight, answer registered at the taking edge
`timescale 1ns/1ns
module suar_init_model (
  // clock
  input wire logic                   mclk,
  // command side
  output logic                       cmd_valid,
  output suar_pkg::suar_cmd_s        cmd,
  // answer side
  input wire logic                   rsp_valid,
  input wire suar_pkg::suar_status_e rsp_status,
  input wire suar_pkg::suar_sense_s  rsp_sense
);
  logic seen_ok;
  logic reissued;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // present a command for one edge and take the answer after it; present it once more if the answer is the 6_2f00 cleared-queue attention
  task automatic issue(input suar_pkg::suar_cmd_s c, output suar_pkg::suar_status_e st,
                       output suar_pkg::suar_sense_s sn);
    reissued = 1'b0;
    for (int n = 0; n < 2; n++) begin
      @(posedge mclk);
      #1 cmd_valid = 1'b1;
      cmd = c;
      @(posedge mclk);
      #1 cmd_valid = 1'b0;
      cmd = ~c; // released bus shows no stale command
      seen_ok = rsp_valid;
      st = rsp_status;
      sn = rsp_sense;
      if (sn != 20'h6_2f00) break;
      reissued = 1'b1;
    end
  endtask : issue
endmodule : suar_init_model

// *** suar_core_tb_top.sv ***
// suar_core_tb_top.sv: self-checking bench for the unit attention core
// assumes: package, partner model and checker compiled before it
`timescale 1ns/1ns
module suar_core_tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, cmd_valid, rsp_valid, rsp_phys_list;
  logic cmd_mismatch_miscmp = 1'b0, dl_too_long = 1'b0, dl_fmt_block = 1'b0, dl_fmt_vendor = 1'b0;
  logic bus_reset_pin = 1'b0, xcvr_mode_pin = 1'b0, target_reset_msg = 1'b0, clear_queue_msg = 1'b0;
  logic format_ready = 1'b0, ucode_valid = 1'b1, ucode_checked = 1'b0, ucode_ver_ok = 1'b1;
  logic powerup_check_done = 1'b0, state_unknown = 1'b0, error_log_event = 1'b0;
  logic queue_discard, abort_all, release_reserve, spindle_stop, stats_clear, failure_prediction_alert;
  logic [3:0]  msg_initiator = 4'h0, format_initiator = 4'h1;
  logic [1:0]  queue_owner = 2'h2;
  logic [31:0] cmd_new_id = 32'h5a5a_0001, device_id;
  suar_pkg::suar_cmd_s cmd;
  suar_pkg::suar_status_e rsp_status;
  suar_pkg::suar_sense_s  rsp_sense;
  suar_pkg::suar_mode_e   drive_mode;
  int err_total = 0, checks = 0;
  always #2 mclk = ~mclk;
  suar_core #(.NUM_INIT(2), .ID_W(32), .PREDICT_THR(16'h0002)) uut (.mclk, .sys_rst, .cmd_valid, .cmd,
    .cmd_mismatch_miscmp, .cmd_new_id, .dl_too_long, .dl_fmt_block, .dl_fmt_vendor, .bus_reset_pin,
    .xcvr_mode_pin, .target_reset_msg, .clear_queue_msg, .msg_initiator, .queue_owner, .format_ready,
    .format_initiator, .ucode_valid, .ucode_checked, .ucode_ver_ok, .powerup_check_done, .state_unknown,
    .error_log_event, .rsp_valid, .rsp_status, .rsp_sense, .rsp_phys_list, .queue_discard, .abort_all,
    .release_reserve, .spindle_stop, .stats_clear, .device_id, .drive_mode, .failure_prediction_alert);
  suar_init_model init (.mclk, .cmd_valid, .cmd, .rsp_valid, .rsp_status, .rsp_sense);
  // ------
  // helpers
  // ------
  task automatic cmp(input string what, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask : pulse
  // one command; zero expected sense means good status
  task automatic run(input logic [3:0] ini, input logic [7:0] op, input logic fl, input logic [19:0] exp);
    suar_pkg::suar_status_e st;
    suar_pkg::suar_sense_s  sn;
    init.issue('{op, ini, fl, 1'b1}, st, sn);
    cmp("answer", 32'(init.seen_ok), 32'h1);
    cmp("status", 32'(st), (exp == 20'h0_0000) ? 32'h0 : 32'h1);
    if (exp != 20'h0_0000) cmp("sense", 32'(sn), 32'(exp));
  endtask : run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // ------
  // scenarios
  // ------
  task automatic t_resets;
    pulse(powerup_check_done);
    run(4'h0, 8'h00, 1'b0, 20'h6_2900);
    run(4'h0, 8'h00, 1'b0, 20'h0_0000);
    run(4'h1, 8'h00, 1'b0, 20'h6_2900);
    for (int k = 0; k < 3; k++) begin
      if (k == 0) pulse(target_reset_msg);
      else if (k == 1) pulse(bus_reset_pin);
      else pulse(xcvr_mode_pin);
      repeat (4) @(posedge mclk);
      run(4'h0, 8'h00, 1'b0, 20'h6_2900);
      run(4'h1, 8'h00, 1'b0, 20'h6_2900);
    end
    $display("done resets");
  endtask : t_resets
  task automatic t_changes;
    logic [7:0]  ops [3] = '{8'h15, 8'h4c, 8'ha4};
    logic [19:0] ua  [3] = '{20'h6_2a01, 20'h6_2a02, 20'h6_3f05};
    for (int i = 0; i < 3; i++) begin
      run(4'h0, ops[i], 1'b0, 20'h0_0000);
      run(4'h1, 8'h00, 1'b0, ua[i]);
      run(4'h0, 8'h00, 1'b0, 20'h0_0000);
    end
    cmp("device_id", device_id, 32'h5a5a_0001);
    pulse(format_ready);
    run(4'h0, 8'h00, 1'b0, 20'h6_2800);
    run(4'h1, 8'h00, 1'b0, 20'h0_0000);
    run(4'h0, 8'h3b, 1'b0, 20'h0_0000);
    run(4'h0, 8'h00, 1'b0, 20'h6_3f01);
    run(4'h1, 8'h00, 1'b0, 20'h6_3f01);
    pulse(clear_queue_msg);
    run(4'h1, 8'h00, 1'b0, 20'h0_0000);
    cmp("reissued", 32'(init.reissued), 32'h1);
    run(4'h0, 8'h00, 1'b0, 20'h0_0000);
    $display("done changes");
  endtask : t_changes
  task automatic t_sense;
    logic [7:0]  ops [7] = '{8'h2f, 8'h2e, 8'h2e, 8'h28, 8'h00, 8'h00, 8'h00};
    logic [4:0]  ctl [7] = '{5'h08, 5'h08, 5'h18, 5'h18, 5'h04, 5'h02, 5'h01};
    logic [19:0] exp [7] = '{20'he_1d00, 20'h0_0000, 20'he_1d00, 20'h0_0000, 20'h1_1f00, 20'h1_1c01, 20'h1_1c02};
    for (int i = 0; i < 7; i++) begin
      {cmd_mismatch_miscmp, dl_too_long, dl_fmt_block, dl_fmt_vendor} = ctl[i][3:0];
      run(4'h1, ops[i], ctl[i][4], exp[i]);
      cmp("phys_list", 32'(rsp_phys_list), 32'(i > 4));
    end
    {cmd_mismatch_miscmp, dl_too_long, dl_fmt_block, dl_fmt_vendor} = 4'h0;
    $display("done sense");
  endtask : t_sense
  task automatic t_faults;
    int n;
    pulse(error_log_event);
    pulse(error_log_event);
    run(4'h0, 8'h00, 1'b0, 20'h0_5d00);
    cmp("alert", 32'(failure_prediction_alert), 32'h1);
    ucode_valid = 1'b0;
    pulse(ucode_checked);
    run(4'h0, 8'h00, 1'b0, 20'h2_4081);
    cmp("mode", 32'(drive_mode), 32'(suar_pkg::SUAR_MODE_DEGRADED));
    ucode_valid = 1'b1;
    pulse(ucode_checked);
    run(4'h0, 8'h00, 1'b0, 20'h0_5d00);
    state_unknown = 1'b1;
    n = 0;
    while (abort_all !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
      if (n > 4) begin
        err_total++;
        end_of_test;
      end
    end
    cmp("self_reset", 32'({release_reserve, spindle_stop}), 32'h3);
    state_unknown = 1'b0;
    run(4'h0, 8'h00, 1'b0, 20'h6_2900);
    run(4'h1, 8'h00, 1'b0, 20'h6_2900);
    ucode_ver_ok = 1'b0;
    pulse(powerup_check_done);
    run(4'h1, 8'h00, 1'b0, 20'h4_4080);
    $display("done faults");
  endtask : t_faults
  initial begin
    repeat (3) @(posedge mclk);
    #1 sys_rst = 1'b0;
    t_resets();
    t_changes();
    t_sense();
    t_faults();
    end_of_test();
  end
endmodule : suar_core_tb_top
bind suar_core suar_core_asserts #(.ID_W(ID_W)) chk (.mclk, .sys_rst, .cmd_valid, .cmd, .cmd_new_id,
  .clear_queue_msg, .ucode_checked, .ucode_valid, .state_unknown, .rsp_valid, .rsp_status, .rsp_sense,
  .queue_discard, .abort_all, .release_reserve, .spindle_stop, .stats_clear, .device_id, .drive_mode,
  .failure_prediction_alert);
